// ### bench/csf_exec_model.sv
// Execution datapath model that issues instructions to the status flag register.
`timescale 1ns/1ps
`default_nettype none
module csf_exec_model (
  // Clock
  input wire logic clk_i,
  // Instruction outputs
  output logic valid_o,
  output var csf_pkg::csf_op_e op_o,
  output logic dest_o,
  output logic [7:0] w_o,
  output logic [7:0] f_o,
  output logic [2:0] bit_o
);
  initial
  begin
    valid_o = 1'b0;
    op_o = csf_pkg::CSF_OP_MOVF;
    dest_o = 1'b0;
    w_o = 8'h00;
    f_o = 8'h00;
    bit_o = 3'h0;
  end

  // Drives one instruction for one cycle, then scrambles the released operands.
  task automatic exec(input csf_pkg::csf_op_e op, input logic dest, input logic [7:0] w,
                      input logic [7:0] f, input logic [2:0] b);
    @(negedge clk_i);
    valid_o = 1'b1;
    op_o = op;
    dest_o = dest;
    w_o = (dest && op == csf_pkg::CSF_OP_MOVE_W_TO_FILE_OP) ? {2'h0, w[5:0]} : w;
    f_o = f;
    bit_o = b;
    @(negedge clk_i);
    valid_o = 1'b0;
    w_o = ~w_o;
    f_o = ~f_o;
  endtask
endmodule
`default_nettype wire

// ### bench/csf_status_reg_test.sv
// Self-checking testbench for the status flag register.
`timescale 1ns/1ps
`default_nettype none
module csf_status_reg_test;
  logic ref_clk;
  logic rst;
  logic valid;
  csf_pkg::csf_op_e op;
  logic dest;
  logic [7:0] w;
  logic [7:0] f;
  logic [2:0] bit_sel;
  logic oth_rst;
  logic wdt_clr;
  logic sleep_en;
  logic wdt_to;
  logic [6:0] dir_addr;
  logic [7:0] status;
  logic [7:0] result;
  logic we;
  logic [7:0] data_addr;
  int errors;
  int comparisons;

  csf_exec_model csf_exec_model_inst (
    .clk_i(ref_clk), .valid_o(valid), .op_o(op), .dest_o(dest),
    .w_o(w), .f_o(f), .bit_o(bit_sel)
  );

  csf_status_reg csf_status_reg_inst (
    .REF_CLK_I(ref_clk), .RST_I(rst), .INSTR_VALID_I(valid), .INSTR_OP_I(op),
    .DEST_STATUS_I(dest), .OPERAND_W_I(w), .OPERAND_F_I(f), .BIT_SEL_I(bit_sel),
    .OTHER_RESET_I(oth_rst), .WDT_CLEAR_I(wdt_clr), .SLEEP_ENTER_I(sleep_en),
    .WDT_TIMEOUT_I(wdt_to), .DIRECT_ADDR_I(dir_addr), .STATUS_O(status),
    .RESULT_O(result), .RESULT_WE_O(we), .DATA_ADDR_O(data_addr)
  );

  // --------------------------------------------------------------------------
  // Clock, checking and verdict
  // --------------------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && comparisons > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Pulses the reset cause events {timeout, sleep, watchdog clear, other reset}.
  task automatic ev(input logic [3:0] e);
    @(negedge ref_clk);
    {wdt_to, sleep_en, wdt_clr, oth_rst} = e;
    @(negedge ref_clk);
    {wdt_to, sleep_en, wdt_clr, oth_rst} = 4'h0;
  endtask

  initial
  begin
    #40000;
    errors++;
    give_verdict();
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    {wdt_to, sleep_en, wdt_clr, oth_rst} = 4'h0;
    dir_addr = 7'h05;
    repeat (5) @(negedge ref_clk);
    check(status, 8'h18);
    rst = 1'b0;
    @(negedge ref_clk);
    check(data_addr, 8'h05);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_SUB, 1'b0, 8'h05, 8'h03, 3'h0);
    check(result, 8'hfe);
    check({7'h00, we}, 8'h01);
    check(status, 8'h18);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_SUB, 1'b0, 8'h03, 8'h05, 3'h0);
    check(result, 8'h02);
    check(status, 8'h1b);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_ADD, 1'b0, 8'hff, 8'h01, 3'h0);
    check(result, 8'h00);
    check(status, 8'h1f);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_MOVE_W_TO_FILE_OP, 1'b1, 8'h22, 8'h00, 3'h0);
    check(status, 8'h3a);
    check({7'h00, we}, 8'h00);
    @(negedge ref_clk);
    check(data_addr, 8'h85);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_BSET, 1'b1, 8'h00, 8'h3a, 3'h0);
    check(status, 8'h3b);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_SWAP, 1'b0, 8'h00, 8'h3c, 3'h0);
    check(result, 8'hc3);
    check(status, 8'h3b);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_CLR, 1'b1, 8'hff, 8'hff, 3'h0);
    check(status, 8'h1f);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_ADD, 1'b1, 8'h21, 8'h02, 3'h0);
    check(status, 8'h38);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_INC, 1'b0, 8'h00, 8'hff, 3'h0);
    check(result, 8'h00);
    check(status, 8'h3c);
    ev(4'h8);
    check(status, 8'h2c);
    check({7'h00, we}, 8'h00);
    ev(4'h4);
    check(status, 8'h34);
    ev(4'h2);
    check(status, 8'h3c);
    ev(4'h1);
    check(status, 8'h1c);
    @(negedge ref_clk);
    check(data_addr, 8'h05);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_XOR, 1'b0, 8'ha5, 8'h5a, 3'h0);
    check(result, 8'hff);
    check(status, 8'h18);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_DEC, 1'b0, 8'h00, 8'h01, 3'h0);
    check(result, 8'h00);
    check(status, 8'h1c);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_IOR, 1'b0, 8'h40, 8'h02, 3'h0);
    check(result, 8'h42);
    check(status, 8'h18);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_AND, 1'b0, 8'hf0, 8'h0f, 3'h0);
    check(result, 8'h00);
    check(status, 8'h1c);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_COM, 1'b0, 8'h00, 8'h0f, 3'h0);
    check(result, 8'hf0);
    check(status, 8'h18);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_MOVF, 1'b0, 8'h00, 8'h00, 3'h0);
    check(result, 8'h00);
    check(status, 8'h1c);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_BCLR, 1'b1, 8'h00, 8'h1c, 3'h2);
    check(status, 8'h18);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_BSET, 1'b0, 8'h00, 8'h00, 3'h7);
    check(result, 8'h80);
    check(status, 8'h18);
    csf_exec_model_inst.exec(csf_pkg::CSF_OP_BSET, 1'b1, 8'h00, 8'h18, 3'h5);
    check(status, 8'h38);
    @(negedge ref_clk);
    check(data_addr, 8'h85);
    rst = 1'b1;
    @(negedge ref_clk);
    check(status, 8'h18);
    check(result, 8'h00);
    check(data_addr, 8'h00);
    rst = 1'b0;
    @(negedge ref_clk);
    check(data_addr, 8'h05);
    give_verdict();
  end
endmodule
`default_nettype wire

// ### src/csf_adder.sv
// Ripple adder that reports the carry out of the low nibble and of the top bit.
`timescale 1ns/1ps
`default_nettype none
module csf_adder #(
  parameter int WIDTH = 8,
  parameter int NIBBLE = 4
) (
  // Operands
  input wire logic [WIDTH-1:0] x_i,
  input wire logic [WIDTH-1:0] y_i,
  input wire logic cin_i,
  // Results
  output logic [WIDTH-1:0] sum_o,
  output logic digit_carry_o,
  output logic carry_o
);

  logic [NIBBLE:0] low_sum;
  logic [WIDTH:0] full_sum;

  always_comb
  begin
    low_sum = {1'b0, x_i[NIBBLE-1:0]} + {1'b0, y_i[NIBBLE-1:0]} + {{NIBBLE{1'b0}}, cin_i};
    full_sum = {1'b0, x_i} + {1'b0, y_i} + {{WIDTH{1'b0}}, cin_i};
    sum_o = full_sum[WIDTH-1:0];
    digit_carry_o = low_sum[NIBBLE];
    carry_o = full_sum[WIDTH];
  end

endmodule
`default_nettype wire

// ### src/csf_params.svh
// Constants for the status flag register block.
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Bit positions inside the status register
// ----------------------------------------------------------------------------
`define CSF_BIT_CARRY 0
`define CSF_BIT_DIGIT 1
`define CSF_BIT_ZERO 2
`define CSF_BIT_PDOWN 3
`define CSF_BIT_TOUT 4
`define CSF_BIT_BANK 5
`define CSF_BIT_UPBANK 6
`define CSF_BIT_INDBANK 7
`define CSF_FIELD_HI_MSB 7
`define CSF_FIELD_HI_LSB 5
`define CSF_FIELD_RC_MSB 4
`define CSF_FIELD_RC_LSB 3
`define CSF_FIELD_ALU_MSB 2
`define CSF_FIELD_ALU_LSB 0

// ----------------------------------------------------------------------------
// Reset values and data constants
// ----------------------------------------------------------------------------
`define CSF_POR_VALUE 8'h18
`define CSF_BYTE_ZERO 8'h00
`define CSF_BYTE_ONES 8'hff
`define CSF_HI_CLEAR 3'h0
`define CSF_NIBBLE_MAX 5'h0f
`define CSF_BANK_OFFSET_W 7
`define CSF_NIBBLE_W 4

`endif

// ### src/csf_pkg.sv
// Types shared by the status flag register block.
package csf_pkg;

  typedef enum logic [3:0] {
    CSF_OP_ADD = 4'h0,
    CSF_OP_SUB = 4'h1,
    CSF_OP_AND = 4'h2,
    CSF_OP_IOR = 4'h3,
    CSF_OP_XOR = 4'h4,
    CSF_OP_COM = 4'h5,
    CSF_OP_INC = 4'h6,
    CSF_OP_DEC = 4'h7,
    CSF_OP_MOVF = 4'h8,
    CSF_OP_CLR = 4'h9,
    CSF_OP_BCLR = 4'ha,
    CSF_OP_BSET = 4'hb,
    CSF_OP_SWAP = 4'hc,
    CSF_OP_MOVE_W_TO_FILE_OP = 4'hd
  } csf_op_e;

  typedef logic [7:0] csf_byte_t;

endpackage

// ### src/csf_status_reg.sv
// Processor status register with flag protection, reset cause and bank select.
// What this block does
// - Status register accepts any instruction's result like other data registers.
// - Flag-updating ops writing status keep data off zero, digit and carry bits.
// - Instruction writes never change timeout or power-down flags.
// - Clearing status clears upper three bits and sets zero, leaving others.
// - Bit clear, bit set, swap and move-from-W leave arithmetic flags alone unless status is their destination.
// - In subtraction carry and digit carry mean no borrow when one.
// - Subtraction adds the two's complement; flags come from that addition.
// - Bank select bit picks bank 0 or bank 1 at 80h, 128 bytes each.
// - One readable byte holds ALU flags, reset cause flags and bank bits.
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"
module csf_status_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Instruction from the execution datapath
  input wire logic INSTR_VALID_I,
  input wire csf_pkg::csf_op_e INSTR_OP_I,
  input wire logic DEST_STATUS_I,
  input wire logic [WIDTH-1:0] OPERAND_W_I,
  input wire logic [WIDTH-1:0] OPERAND_F_I,
  input wire logic [2:0] BIT_SEL_I,
  // Reset cause events
  input wire logic OTHER_RESET_I,
  input wire logic WDT_CLEAR_I,
  input wire logic SLEEP_ENTER_I,
  input wire logic WDT_TIMEOUT_I,
  // Direct addressing
  input wire logic [`CSF_BANK_OFFSET_W-1:0] DIRECT_ADDR_I,
  // Results
  output logic [WIDTH-1:0] STATUS_O,
  output logic [WIDTH-1:0] RESULT_O,
  output logic RESULT_WE_O,
  output logic [`CSF_BANK_OFFSET_W:0] DATA_ADDR_O
);

  // --------------------------------------------------------------------------
  // Arithmetic
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] add_x;
  logic [WIDTH-1:0] add_y;
  logic add_cin;
  logic [WIDTH-1:0] add_sum;
  logic add_dc;
  logic add_c;

  csf_adder #(
    .WIDTH(WIDTH),
    .NIBBLE(`CSF_NIBBLE_W)
  ) csf_adder_inst (
    .x_i(add_x),
    .y_i(add_y),
    .cin_i(add_cin),
    .sum_o(add_sum),
    .digit_carry_o(add_dc),
    .carry_o(add_c)
  );

  logic [WIDTH-1:0] res;
  logic sets_zero;
  logic sets_carry;
  logic [WIDTH-1:0] bit_mask;

  always_comb
  begin
    add_x = OPERAND_F_I;
    add_y = `CSF_BYTE_ZERO;
    add_cin = 1'b0;
    res = `CSF_BYTE_ZERO;
    sets_zero = 1'b0;
    sets_carry = 1'b0;
    bit_mask = WIDTH'(1) << BIT_SEL_I;
    unique case (INSTR_OP_I)
      csf_pkg::CSF_OP_ADD:
      begin
        add_y = OPERAND_W_I;
        res = add_sum;
        sets_zero = 1'b1;
        sets_carry = 1'b1;
      end
      csf_pkg::CSF_OP_SUB:
      begin
        add_y = ~OPERAND_W_I;
        add_cin = 1'b1;
        res = add_sum;
        sets_zero = 1'b1;
        sets_carry = 1'b1;
      end
      csf_pkg::CSF_OP_INC:
      begin
        add_cin = 1'b1;
        res = add_sum;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_DEC:
      begin
        add_y = `CSF_BYTE_ONES;
        res = add_sum;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_AND:
      begin
        res = OPERAND_W_I & OPERAND_F_I;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_IOR:
      begin
        res = OPERAND_W_I | OPERAND_F_I;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_XOR:
      begin
        res = OPERAND_W_I ^ OPERAND_F_I;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_COM:
      begin
        res = ~OPERAND_F_I;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_MOVF:
      begin
        res = OPERAND_F_I;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_CLR:
      begin
        res = `CSF_BYTE_ZERO;
        sets_zero = 1'b1;
      end
      csf_pkg::CSF_OP_BCLR: res = OPERAND_F_I & ~bit_mask;
      csf_pkg::CSF_OP_BSET: res = OPERAND_F_I | bit_mask;
      csf_pkg::CSF_OP_SWAP:
      begin
        res = {OPERAND_F_I[`CSF_NIBBLE_W-1:0], OPERAND_F_I[WIDTH-1:`CSF_NIBBLE_W]};
      end
      csf_pkg::CSF_OP_MOVE_W_TO_FILE_OP: res = OPERAND_W_I;
      default: res = OPERAND_F_I;
    endcase
  end

  // --------------------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] status_reg;
  logic [WIDTH-1:0] status_next;

  always_comb
  begin
    status_next = status_reg;
    if (INSTR_VALID_I && DEST_STATUS_I)
    begin
      status_next[`CSF_FIELD_HI_MSB:`CSF_FIELD_HI_LSB] =
        res[`CSF_FIELD_HI_MSB:`CSF_FIELD_HI_LSB];
      if (!sets_zero)
      begin
        status_next[`CSF_FIELD_ALU_MSB:`CSF_FIELD_ALU_LSB] =
          res[`CSF_FIELD_ALU_MSB:`CSF_FIELD_ALU_LSB];
      end
    end
    if (INSTR_VALID_I && sets_zero)
    begin
      status_next[`CSF_BIT_ZERO] = (res == `CSF_BYTE_ZERO);
    end
    if (INSTR_VALID_I && sets_carry)
    begin
      status_next[`CSF_BIT_DIGIT] = add_dc;
      status_next[`CSF_BIT_CARRY] = add_c;
    end
    if (WDT_TIMEOUT_I)
    begin
      status_next[`CSF_BIT_TOUT] = 1'b0;
    end
    if (SLEEP_ENTER_I)
    begin
      status_next[`CSF_BIT_PDOWN] = 1'b0;
      status_next[`CSF_BIT_TOUT] = 1'b1;
    end
    if (WDT_CLEAR_I)
    begin
      status_next[`CSF_BIT_TOUT] = 1'b1;
      status_next[`CSF_BIT_PDOWN] = 1'b1;
    end
    if (OTHER_RESET_I)
    begin
      status_next[`CSF_FIELD_HI_MSB:`CSF_FIELD_HI_LSB] = `CSF_HI_CLEAR;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      status_reg <= `CSF_POR_VALUE;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // --------------------------------------------------------------------------
  // Result and address outputs
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] result_reg;
  logic [WIDTH-1:0] result_next;
  logic result_we_reg;
  logic result_we_next;
  logic [`CSF_BANK_OFFSET_W:0] addr_reg;
  logic [`CSF_BANK_OFFSET_W:0] addr_next;

  always_comb
  begin
    result_next = result_reg;
    result_we_next = INSTR_VALID_I && !DEST_STATUS_I;
    if (result_we_next)
    begin
      result_next = res;
    end
    addr_next = {status_reg[`CSF_BIT_BANK], DIRECT_ADDR_I};
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      result_reg <= `CSF_BYTE_ZERO;
      result_we_reg <= 1'b0;
      addr_reg <= '0;
    end
    else
    begin
      result_reg <= result_next;
      result_we_reg <= result_we_next;
      addr_reg <= addr_next;
    end
  end

  assign STATUS_O = status_reg;
  assign RESULT_O = result_reg;
  assign RESULT_WE_O = result_we_reg;
  assign DATA_ADDR_O = addr_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  logic no_events;
  assign no_events = !OTHER_RESET_I && !WDT_CLEAR_I && !SLEEP_ENTER_I && !WDT_TIMEOUT_I;

  AST_RC_READ_ONLY: assert property (INSTR_VALID_I && DEST_STATUS_I && no_events
    |=> STATUS_O[`CSF_FIELD_RC_MSB:`CSF_FIELD_RC_LSB] ==
      $past(STATUS_O[`CSF_FIELD_RC_MSB:`CSF_FIELD_RC_LSB]))
    else $error("Reset cause flags changed by an instruction write.");

  AST_FLAG_BLOCK: assert property (INSTR_VALID_I && DEST_STATUS_I
    && INSTR_OP_I == csf_pkg::CSF_OP_ADD |=> STATUS_O[`CSF_BIT_CARRY] == $past(add_c)
    && STATUS_O[`CSF_BIT_DIGIT] == $past(add_dc))
    else $error("Carry flags took write data instead of the result.");

  AST_CLEAR_STATUS: assert property (INSTR_VALID_I && DEST_STATUS_I && no_events
    && INSTR_OP_I == csf_pkg::CSF_OP_CLR |=> STATUS_O[`CSF_FIELD_HI_MSB:`CSF_FIELD_HI_LSB]
      == `CSF_HI_CLEAR && STATUS_O[`CSF_BIT_ZERO]
      && STATUS_O[`CSF_BIT_DIGIT:`CSF_BIT_CARRY] == $past(STATUS_O[`CSF_BIT_DIGIT:`CSF_BIT_CARRY]))
    else $error("Clearing status gave a wrong value.");

  AST_QUIET_OPS: assert property (INSTR_VALID_I && !DEST_STATUS_I
    && INSTR_OP_I inside {csf_pkg::CSF_OP_BCLR, csf_pkg::CSF_OP_BSET,
      csf_pkg::CSF_OP_SWAP, csf_pkg::CSF_OP_MOVE_W_TO_FILE_OP}
    |=> STATUS_O[`CSF_FIELD_ALU_MSB:`CSF_FIELD_ALU_LSB]
      == $past(STATUS_O[`CSF_FIELD_ALU_MSB:`CSF_FIELD_ALU_LSB]))
    else $error("A flag-neutral operation changed the arithmetic flags.");

  AST_SUB_BORROW: assert property (INSTR_VALID_I && !DEST_STATUS_I
    && INSTR_OP_I == csf_pkg::CSF_OP_SUB
    |=> STATUS_O[`CSF_BIT_CARRY] == ($past(OPERAND_W_I) <= $past(OPERAND_F_I)))
    else $error("Borrow flag polarity is wrong.");

  AST_SUB_RESULT: assert property (INSTR_VALID_I && !DEST_STATUS_I
    && INSTR_OP_I == csf_pkg::CSF_OP_SUB
    |=> RESULT_WE_O && RESULT_O == WIDTH'($past(OPERAND_F_I) - $past(OPERAND_W_I)))
    else $error("Subtraction result is wrong.");

  AST_BANK_ADDR: assert property (1'b1 |-> ##1 DATA_ADDR_O ==
    {$past(STATUS_O[`CSF_BIT_BANK]), $past(DIRECT_ADDR_I)} ##1
    DATA_ADDR_O[`CSF_BANK_OFFSET_W] == $past(STATUS_O[`CSF_BIT_BANK]))
    else $error("Direct address does not follow the bank select bit.");

  AST_STATUS_VIEW: assert property (INSTR_VALID_I && DEST_STATUS_I && no_events
    && INSTR_OP_I == csf_pkg::CSF_OP_MOVE_W_TO_FILE_OP |=> STATUS_O ==
      {$past(OPERAND_W_I[`CSF_FIELD_HI_MSB:`CSF_FIELD_HI_LSB]),
      $past(STATUS_O[`CSF_FIELD_RC_MSB:`CSF_FIELD_RC_LSB]),
      $past(OPERAND_W_I[`CSF_FIELD_ALU_MSB:`CSF_FIELD_ALU_LSB])})
    else $error("Status byte does not show the moved value.");

  AST_ADD_FLAGS: assert property (INSTR_VALID_I && !DEST_STATUS_I
    && INSTR_OP_I == csf_pkg::CSF_OP_ADD |=> STATUS_O[`CSF_BIT_ZERO] == (RESULT_O == '0)
    && STATUS_O[`CSF_BIT_DIGIT] == (({1'b0, $past(OPERAND_W_I[3:0])}
      + {1'b0, $past(OPERAND_F_I[3:0])}) > `CSF_NIBBLE_MAX))
    else $error("Zero or digit carry flag is wrong after an add.");

  AST_SLEEP: assert property (SLEEP_ENTER_I && !WDT_CLEAR_I
    |=> STATUS_O[`CSF_BIT_TOUT] && !STATUS_O[`CSF_BIT_PDOWN])
    else $error("Sleep entry gave wrong reset cause flags.");

  AST_TIMEOUT: assert property (WDT_TIMEOUT_I && !WDT_CLEAR_I && !SLEEP_ENTER_I
    |=> !STATUS_O[`CSF_BIT_TOUT])
    else $error("Watchdog timeout did not clear the timeout flag.");

  COV_SUB_BORROW: cover property (INSTR_VALID_I && INSTR_OP_I == csf_pkg::CSF_OP_SUB
    ##1 !STATUS_O[`CSF_BIT_CARRY]);
  COV_CLEAR_STATUS: cover property (INSTR_VALID_I && DEST_STATUS_I
    && INSTR_OP_I == csf_pkg::CSF_OP_CLR);
  COV_BANK_ONE: cover property (STATUS_O[`CSF_BIT_BANK] ##1 DATA_ADDR_O[`CSF_BANK_OFFSET_W]);
  COV_SLEEP: cover property (SLEEP_ENTER_I ##1 !STATUS_O[`CSF_BIT_PDOWN]);

endmodule
`default_nettype wire
